// file: design/tdp_map.vh
`ifndef TDP_MAP_VH
`define TDP_MAP_VH
// Register offsets (8-bit command space)
`define TDP_CTRL_STATUS 8'h00
`define TDP_SAFETY_STATUS_A 8'h05
`define TDP_SAFETY_STATUS_B 8'h03
`define TDP_SAFETY_ALERT_B 8'h02
`define TDP_PROT_ENABLE 8'h40
`define TDP_COLD_THRESH 8'h41
`define TDP_COLD_DELAY 8'h42
`define TDP_COLD_RECOV 8'h43
`define TDP_DSG_PROT 8'h44
`define TDP_BOTH_PROT 8'h45
`define TDP_OPEN_WIRE 8'h46
`define TDP_POWER_CFG 8'h47
`define TDP_FET_MODE 8'h48
`define TDP_AUX_REG_CTRL 8'h69
`define TDP_SUBCMD_LO 8'h3E
`define TDP_SUBCMD_HI 8'h3F
`define TDP_SUBCMD_ADDR 8'h4A
`define TDP_FET_STATE 8'h4B
// Subcommand codes
`define TDP_PROTECTION_RECOVERY_SUBCMD_SUBCMD 16'h009B
// Field positions
`define TDP_EN_COLD 0
`define TDP_EN_VREF 1
`define TDP_EN_GND 2
`define TDP_EN_AUX 3
`define TDP_REC_TEMP 0
`define TDP_REC_DIAG 1
`define TDP_OW_EN 3
`define TDP_PWR_OVERTEMP_SHUTDOWN_ENABLE 0
`define TDP_PWR_OSCILLATOR_WATCHDOG_ENABLE 1
`define TDP_AUXC_BIAS 3
`define TDP_FLAG_COLD 0
`define TDP_FLAG_VREF 1
`define TDP_FLAG_GND 2
`define TDP_FLAG_AUX 0
// Reset values
`define TDP_PROT_ENABLE_RST 8'h00
`define TDP_COLD_THRESH_RST 8'h00
`define TDP_COLD_DELAY_RST 8'h00
`define TDP_COLD_RECOV_RST 8'h00
`define TDP_OPEN_WIRE_RST 8'h00
`define TDP_POWER_CFG_RST 8'h00
`define TDP_AUX_REG_CTRL_RST 8'h00
// Timing
`define TDP_OW_ON_TIME_US 2930
`define TDP_CLK_MHZ 100
`define TDP_OW_ON_CYCLES ((`TDP_OW_ON_TIME_US * `TDP_CLK_MHZ))
`define TDP_CELLS 7
`endif

// file: design/tdp_sync2.v
`timescale 1ns/100ps
module tdp_sync2 #(
  parameter W = 1
)(
  input wire clk,
  input wire resetn,
  input wire ce,
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);
  reg [W-1:0] meta_q;
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      meta_q <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end
    else if (ce)
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// file: design/tdp_diag_qual.v
`timescale 1ns/100ps
// Two-interval qualifier; fault held until host recovery
module tdp_diag_qual (
  input wire clk,
  input wire resetn,
  input wire ce,
  input wire tick,
  input wire enable,
  input wire cond,
  input wire recover,
  output reg alert_q,
  output reg fault_q
);
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      alert_q <= 1'b0;
      fault_q <= 1'b0;
    end
    else if (ce)
    begin
      if (tick && enable && cond && alert_q)
        fault_q <= 1'b1;
      else if (recover)
        fault_q <= 1'b0;
      if (tick)
        alert_q <= enable && cond && !(alert_q || fault_q);
    end
  end
endmodule

// file: design/tdp_top.v
// Our own choices: strobed register access and the address map.
`timescale 1ns/100ps
`include "tdp_map.vh"
module tdp_top #(
  parameter [15:0] SIGNATURE = 16'h5A5A, // Arbitrary value
  parameter OW_ON_CYCLES = `TDP_OW_ON_CYCLES
)(
  input wire clk,
  input wire resetn,
  input wire ce,
  input wire [7:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  output reg [15:0] rdata,
  input wire check_tick,
  input wire [7:0] thermistor_code,
  input wire thermistor_valid,
  input wire vref_deviation,
  input wire gnd_above_limit,
  input wire aux_reg_ilimit,
  input wire aux_reg_overtemp,
  input wire osc_fault,
  input wire trim_error,
  input wire trim_done,
  output wire thermistor_bias_on,
  output wire thermistor_eval_req,
  output reg [6:0] open_wire_source,
  output wire aux_regulator_on,
  output wire discharge_switch,
  output wire charge_switch,
  output reg shutdown_req
);
  ////////////////////////////////////////////////////////////////////////
  wire [7:0] pin_s;
  wire thm_valid_s;
  wire vref_s;
  wire gnd_s;
  wire ilim_s;
  wire ot_s;
  wire osc_s;
  wire trim_err_s;
  wire trim_done_s;
  tdp_sync2 #(.W(16)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .async_in({thermistor_code, thermistor_valid, vref_deviation, gnd_above_limit,
      aux_reg_ilimit, aux_reg_overtemp, osc_fault, trim_error, trim_done}),
    .sync_out({pin_s, thm_valid_s, vref_s, gnd_s, ilim_s, ot_s, osc_s, trim_err_s, trim_done_s})
  );
  ////////////////////////////////////////////////////////////////////////
  reg [7:0] prot_enable_q;
  reg [7:0] cold_thresh_q;
  reg [7:0] cold_delay_q;
  reg [7:0] cold_recov_q;
  reg [7:0] dsg_prot_q;
  reg [7:0] both_prot_q;
  reg [7:0] open_wire_q;
  reg [7:0] power_cfg_q;
  reg [7:0] aux_ctrl_q;
  reg fet_mode_q;
  reg [1:0] fet_state_q;
  reg [15:0] subcmd_q;
  reg sig_armed_q;
  reg cold_alert_q;
  reg cold_fault_q;
  reg [7:0] cold_cnt_q;
  reg aux_fault_q;
  wire vref_alert;
  wire vref_fault;
  wire gnd_alert;
  wire gnd_fault;
  wire recov_cmd;
  wire temp_rec;
  wire diag_rec;
  // Subcommand written via low/high bytes or legacy port
  assign recov_cmd = ce && wr && (addr == `TDP_SUBCMD_HI) &&
    ({wdata[7:0], subcmd_q[7:0]} == `TDP_PROTECTION_RECOVERY_SUBCMD_SUBCMD);
  assign temp_rec = recov_cmd && wdata[8 + `TDP_REC_TEMP];
  assign diag_rec = recov_cmd && wdata[8 + `TDP_REC_DIAG];
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      prot_enable_q <= `TDP_PROT_ENABLE_RST;
      cold_thresh_q <= `TDP_COLD_THRESH_RST;
      cold_delay_q <= `TDP_COLD_DELAY_RST;
      cold_recov_q <= `TDP_COLD_RECOV_RST;
      dsg_prot_q <= 8'h00;
      both_prot_q <= 8'h00;
      open_wire_q <= `TDP_OPEN_WIRE_RST;
      power_cfg_q <= `TDP_POWER_CFG_RST;
      aux_ctrl_q <= `TDP_AUX_REG_CTRL_RST;
      fet_mode_q <= 1'b0;
      fet_state_q <= 2'b00;
      subcmd_q <= 16'h0000;
      sig_armed_q <= 1'b0;
    end
    else if (ce)
    begin
      if (wr)
      begin
        case (addr)
          `TDP_PROT_ENABLE: prot_enable_q <= wdata[7:0];
          `TDP_COLD_THRESH: cold_thresh_q <= wdata[7:0];
          `TDP_COLD_DELAY: cold_delay_q <= wdata[7:0];
          `TDP_COLD_RECOV: cold_recov_q <= wdata[7:0];
          `TDP_DSG_PROT: dsg_prot_q <= wdata[7:0];
          `TDP_BOTH_PROT: both_prot_q <= wdata[7:0];
          `TDP_OPEN_WIRE: open_wire_q <= wdata[7:0];
          `TDP_POWER_CFG: power_cfg_q <= wdata[7:0];
          `TDP_AUX_REG_CTRL: aux_ctrl_q <= wdata[7:0];
          `TDP_FET_MODE: fet_mode_q <= wdata[0];
          `TDP_FET_STATE: fet_state_q <= wdata[1:0];
          `TDP_SUBCMD_LO: subcmd_q[7:0] <= wdata[7:0];
          `TDP_SUBCMD_HI: subcmd_q[15:8] <= wdata[7:0];
          `TDP_CTRL_STATUS: subcmd_q <= wdata;
          default: subcmd_q <= subcmd_q;
        endcase
      end
      // Signature armed only by a write, spent by the next access
      if (wr)
        sig_armed_q <= (addr == `TDP_CTRL_STATUS);
      else if (rd)
        sig_armed_q <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Cold-discharge: code counts rail/252 steps, higher code = colder
  wire cold_en;
  wire cold_cond;
  wire cold_ok;
  assign cold_en = prot_enable_q[`TDP_EN_COLD];
  assign cold_cond = pin_s > cold_thresh_q;
  assign cold_ok = (cold_recov_q != 8'h00) && (pin_s <= cold_recov_q);
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      cold_alert_q <= 1'b0;
      cold_fault_q <= 1'b0;
      cold_cnt_q <= 8'h00;
    end
    else if (ce)
    begin
      if (cold_fault_q)
      begin
        cold_alert_q <= 1'b0;
        cold_cnt_q <= 8'h00;
        if ((thm_valid_s && cold_ok) || temp_rec)
          cold_fault_q <= 1'b0;
      end
      else if (check_tick && thm_valid_s)
      begin
        if (cold_en && cold_cond)
        begin
          if (cold_cnt_q >= cold_delay_q)
          begin
            cold_fault_q <= 1'b1;
            cold_alert_q <= 1'b0;
            cold_cnt_q <= 8'h00;
          end
          else
          begin
            cold_alert_q <= 1'b1;
            cold_cnt_q <= cold_cnt_q + 8'h01;
          end
        end
        else
        begin
          cold_alert_q <= 1'b0;
          cold_cnt_q <= 8'h00;
        end
      end
    end
  end
  // Pull-up only while a reading is requested, unless held on
  reg eval_q;
  always @(posedge clk)
  begin
    if (!resetn)
      eval_q <= 1'b0;
    else if (ce)
    begin
      if (check_tick)
        eval_q <= 1'b1;
      else if (thm_valid_s)
        eval_q <= 1'b0;
    end
  end
  assign thermistor_eval_req = eval_q;
  assign thermistor_bias_on = eval_q || aux_ctrl_q[`TDP_AUXC_BIAS];
  ////////////////////////////////////////////////////////////////////////
  tdp_diag_qual u_vref (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .tick(check_tick),
    .enable(prot_enable_q[`TDP_EN_VREF]),
    .cond(vref_s),
    .recover(diag_rec),
    .alert_q(vref_alert),
    .fault_q(vref_fault)
  );
  tdp_diag_qual u_gnd (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .tick(check_tick),
    .enable(prot_enable_q[`TDP_EN_GND]),
    .cond(gnd_s),
    .recover(diag_rec),
    .alert_q(gnd_alert),
    .fault_q(gnd_fault)
  );
  ////////////////////////////////////////////////////////////////////////
  // Regulator fault follows its cause; no latch
  always @(posedge clk)
  begin
    if (!resetn)
      aux_fault_q <= 1'b0;
    else if (ce)
      aux_fault_q <= ilim_s || ot_s;
  end
  assign aux_regulator_on = aux_ctrl_q[0] && !aux_fault_q;
  wire aux_flag;
  assign aux_flag = aux_fault_q && prot_enable_q[`TDP_EN_AUX];
  // Shutdown is sticky until reset; trim check gates first use
  always @(posedge clk)
  begin
    if (!resetn)
      shutdown_req <= 1'b0;
    else if (ce)
    begin
      if (ot_s && power_cfg_q[`TDP_PWR_OVERTEMP_SHUTDOWN_ENABLE])
        shutdown_req <= 1'b1;
      if (osc_s && power_cfg_q[`TDP_PWR_OSCILLATOR_WATCHDOG_ENABLE])
        shutdown_req <= 1'b1;
      if (trim_done_s && trim_err_s)
        shutdown_req <= 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  wire dsg_block;
  wire chg_block;
  assign dsg_block = (cold_fault_q && dsg_prot_q[`TDP_FLAG_COLD])
    || (vref_fault && both_prot_q[`TDP_FLAG_VREF])
    || (gnd_fault && both_prot_q[`TDP_FLAG_GND])
    || (aux_flag && both_prot_q[3]);
  assign chg_block = (vref_fault && both_prot_q[`TDP_FLAG_VREF])
    || (gnd_fault && both_prot_q[`TDP_FLAG_GND])
    || (aux_flag && both_prot_q[3]);
  // Autonomous mode overrides host FET state only to open switches
  assign discharge_switch = fet_state_q[0] && !(fet_mode_q && dsg_block) && !shutdown_req;
  assign charge_switch = fet_state_q[1] && !(fet_mode_q && chg_block) && !shutdown_req;
  ////////////////////////////////////////////////////////////////////////
  // Open-wire scheduler: 2.93 ms slots, one cell at a time
  reg [2:0] ow_cell_q;
  reg [2:0] ow_skip_q;
  reg [4:0] ow_left_q;
  reg [18:0] ow_timer_q;
  reg ow_busy_q;
  wire [2:0] ow_rate;
  reg [4:0] ow_burst;
  reg [2:0] ow_period;
  assign ow_rate = open_wire_q[2:0];
  always @*
  begin
    ow_burst = 5'd1;
    ow_period = 3'd0;
    case (ow_rate)
      3'h0: ow_period = 3'd7;
      3'h1: ow_period = 3'd3;
      3'h2: ow_period = 3'd1;
      3'h3: ow_period = 3'd0;
      3'h4: ow_burst = 5'd2;
      3'h5: ow_burst = 5'd4;
      3'h6: ow_burst = 5'd8;
      3'h7: ow_burst = 5'd16;
      default: ow_burst = 5'd1;
    endcase
  end
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      ow_cell_q <= 3'd0;
      ow_skip_q <= 3'd0;
      ow_left_q <= 5'd0;
      ow_timer_q <= 19'd0;
      ow_busy_q <= 1'b0;
      open_wire_source <= 7'h00;
    end
    else if (ce)
    begin
      if (!open_wire_q[`TDP_OW_EN])
      begin
        ow_busy_q <= 1'b0;
        ow_left_q <= 5'd0;
        open_wire_source <= 7'h00;
      end
      else if (ow_busy_q)
      begin
        if (ow_timer_q == 19'd0)
        begin
          ow_busy_q <= 1'b0;
          open_wire_source <= 7'h00;
          ow_cell_q <= (ow_cell_q == 3'd6) ? 3'd0 : ow_cell_q + 3'd1;
        end
        else
          ow_timer_q <= ow_timer_q - 19'd1;
      end
      else if (ow_left_q != 5'd0)
      begin
        ow_busy_q <= 1'b1;
        ow_left_q <= ow_left_q - 5'd1;
        ow_timer_q <= OW_ON_CYCLES[18:0] - 19'd1;
        open_wire_source <= 7'h01 << ow_cell_q;
      end
      else if (check_tick)
      begin
        if (ow_skip_q == 3'd0)
        begin
          ow_left_q <= ow_burst;
          ow_skip_q <= ow_period;
        end
        else
          ow_skip_q <= ow_skip_q - 3'd1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    if (!resetn)
      rdata <= 16'h0000;
    else if (ce && rd)
    begin
      case (addr)
        `TDP_CTRL_STATUS: rdata <= sig_armed_q ? SIGNATURE : 16'h0000;
        `TDP_SAFETY_ALERT_B: rdata <= {13'h0000, gnd_alert, vref_alert, cold_alert_q};
        `TDP_SAFETY_STATUS_B: rdata <= {13'h0000, gnd_fault, vref_fault, cold_fault_q};
        `TDP_SAFETY_STATUS_A: rdata <= {15'h0000, aux_flag};
        `TDP_PROT_ENABLE: rdata <= {8'h00, prot_enable_q};
        `TDP_COLD_THRESH: rdata <= {8'h00, cold_thresh_q};
        `TDP_COLD_DELAY: rdata <= {8'h00, cold_delay_q};
        `TDP_COLD_RECOV: rdata <= {8'h00, cold_recov_q};
        `TDP_DSG_PROT: rdata <= {8'h00, dsg_prot_q};
        `TDP_BOTH_PROT: rdata <= {8'h00, both_prot_q};
        `TDP_OPEN_WIRE: rdata <= {8'h00, open_wire_q};
        `TDP_POWER_CFG: rdata <= {8'h00, power_cfg_q};
        `TDP_AUX_REG_CTRL: rdata <= {8'h00, aux_ctrl_q};
        `TDP_FET_MODE: rdata <= {15'h0000, fet_mode_q};
        `TDP_FET_STATE: rdata <= {12'h000, charge_switch, discharge_switch, fet_state_q};
        `TDP_SUBCMD_ADDR: rdata <= subcmd_q;
        default: rdata <= 16'h0000;
      endcase
    end
    else if (ce)
      rdata <= 16'h0000;
  end
endmodule

// file: verif/tdp_top_sva.sv
`timescale 1ns/100ps
module tdp_top_sva #(
  parameter [15:0] SIGNATURE = 16'h5A5A,
  parameter OW_ON_CYCLES = 293000
)(
  input wire clk,
  input wire resetn,
  input wire ce,
  input wire [7:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  input wire [15:0] rdata,
  input wire check_tick,
  input wire [7:0] thermistor_code,
  input wire thermistor_valid,
  input wire vref_deviation,
  input wire gnd_above_limit,
  input wire aux_reg_ilimit,
  input wire aux_reg_overtemp,
  input wire osc_fault,
  input wire trim_error,
  input wire trim_done,
  input wire thermistor_bias_on,
  input wire thermistor_eval_req,
  input wire [6:0] open_wire_source,
  input wire aux_regulator_on,
  input wire discharge_switch,
  input wire charge_switch,
  input wire shutdown_req
);
  reg bias_q;
  reg reg_en_q;
  reg osc_wd_q;
  // Shadow of the few control bits the assertions need, taken from the write port
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      bias_q <= 1'b0;
      reg_en_q <= 1'b0;
      osc_wd_q <= 1'b0;
    end
    else if (ce && wr)
    begin
      if (addr == 8'h69)
      begin
        bias_q <= wdata[3];
        reg_en_q <= wdata[0];
      end
      if (addr == 8'h47)
        osc_wd_q <= wdata[1];
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence sig_arm_s;
    (wr && addr == 8'h00) ##1 (rd && addr == 8'h00);
  endsequence
  sig_read_a: assert property (sig_arm_s |=> rdata == SIGNATURE)
    else $error("signature word not returned");
  sig_once_a: assert property (sig_arm_s ##1 (rd && addr == 8'h00) |=> rdata != SIGNATURE)
    else $error("signature word returned twice");
  sd_hold_a: assert property (shutdown_req |=> shutdown_req)
    else $error("shutdown request dropped");
  osc_sd_a: assert property (osc_wd_q && osc_fault [*4] |-> ##[0:2] shutdown_req)
    else $error("no shutdown on oscillator failure");
  trim_sd_a: assert property ((trim_done && trim_error) [*4] |-> ##[0:2] shutdown_req)
    else $error("no shutdown on trim error");
  bias_eq_a: assert property (thermistor_bias_on == (thermistor_eval_req || bias_q))
    else $error("thermistor bias wrong");
  ow_hot_a: assert property ($onehot0(open_wire_source))
    else $error("more than one cell source on");
  // Slot length is at least ten cycles in the bench, so eight stable cycles must follow
  ow_hold_a: assert property ($changed(open_wire_source) && open_wire_source != 7'h00 |=> $stable(open_wire_source) [*8])
    else $error("cell source slot too short");
  aux_off_a: assert property ((aux_reg_ilimit || aux_reg_overtemp) [*5] |-> !aux_regulator_on)
    else $error("regulator left on during error");
  aux_back_a: assert property ((reg_en_q && !aux_reg_ilimit && !aux_reg_overtemp) [*6] |-> aux_regulator_on)
    else $error("regulator not restored");
endmodule
bind tdp_top tdp_top_sva #(.SIGNATURE(SIGNATURE), .OW_ON_CYCLES(OW_ON_CYCLES)) tdp_top_sva_i (
  .clk(clk), .resetn(resetn), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .check_tick(check_tick), .thermistor_code(thermistor_code), .thermistor_valid(thermistor_valid),
  .vref_deviation(vref_deviation), .gnd_above_limit(gnd_above_limit), .aux_reg_ilimit(aux_reg_ilimit),
  .aux_reg_overtemp(aux_reg_overtemp), .osc_fault(osc_fault), .trim_error(trim_error), .trim_done(trim_done),
  .thermistor_bias_on(thermistor_bias_on), .thermistor_eval_req(thermistor_eval_req),
  .open_wire_source(open_wire_source), .aux_regulator_on(aux_regulator_on),
  .discharge_switch(discharge_switch), .charge_switch(charge_switch), .shutdown_req(shutdown_req));

// file: verif/tdp_host.sv
`timescale 1ns/100ps
module tdp_host (
  input wire clk,
  input wire [15:0] rdata,
  output reg [7:0] addr,
  output reg [15:0] wdata,
  output reg wr,
  output reg rd
);
  initial
  begin
    addr = 8'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
  end
  // Strobes stay up on exit so accesses can follow with no gap
  task xfer(input w, input r, input [7:0] a, input [15:0] d, output [15:0] q);
  begin
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    #1;
    q = rdata;
  end
  endtask
  task idle;
  begin
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
    #1;
  end
  endtask
  task wr_reg(input [7:0] a, input [15:0] d);
    reg [15:0] q;
  begin
    xfer(1'b1, 1'b0, a, d, q);
    idle;
  end
  endtask
  task rd_reg(input [7:0] a, output [15:0] q);
  begin
    xfer(1'b0, 1'b1, a, 16'h0000, q);
    idle;
  end
  endtask
  task recover(input temp, input diag);
    reg [15:0] q;
  begin
    xfer(1'b1, 1'b0, 8'h3E, 16'h009B, q);
    xfer(1'b1, 1'b0, 8'h3F, {6'h00, diag, temp, 8'h00}, q);
    idle;
  end
  endtask
endmodule

// file: verif/test_temp_and_diag_protection.sv
`timescale 1ns/100ps
module test_temp_and_diag_protection;
  localparam [15:0] SIG = 16'hC3A1; // Arbitrary value
  reg clk = 1'b0;
  reg resetn = 1'b0;
  reg check_tick = 1'b0;
  reg ce = 1'b1;
  reg [7:0] thermistor_code = 8'h00;
  reg thermistor_valid = 1'b1;
  reg vref_deviation = 1'b0;
  reg gnd_above_limit = 1'b0;
  reg aux_reg_ilimit = 1'b0;
  reg aux_reg_overtemp = 1'b0;
  reg osc_fault = 1'b0;
  reg trim_error = 1'b0;
  reg trim_done = 1'b1;
  wire [7:0] addr;
  wire [15:0] wdata, rdata;
  wire wr, rd, thermistor_bias_on, thermistor_eval_req, aux_regulator_on, discharge_switch, charge_switch, shutdown_req;
  wire [6:0] open_wire_source;
  reg [6:0] ow_prev = 7'h00;
  reg [31:0] seed = 32'h62b74659;
  reg [15:0] q, q2;
  integer fails = 0, tests_run = 0, cyc = 0, ow_cnt = 0;
  integer t, d, r, en, cnt, al, ft, i, k;
  integer ofs [0:8] = '{0, 1, 0, 1, 1, 1, 1, -4, -5};
  tdp_host tdp_host_i (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
  tdp_top #(.SIGNATURE(SIG), .OW_ON_CYCLES(10)) tdp_top_i (
    .clk(clk), .resetn(resetn), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .check_tick(check_tick), .thermistor_code(thermistor_code), .thermistor_valid(thermistor_valid),
    .vref_deviation(vref_deviation), .gnd_above_limit(gnd_above_limit), .aux_reg_ilimit(aux_reg_ilimit),
    .aux_reg_overtemp(aux_reg_overtemp), .osc_fault(osc_fault), .trim_error(trim_error), .trim_done(trim_done),
    .thermistor_bias_on(thermistor_bias_on), .thermistor_eval_req(thermistor_eval_req),
    .open_wire_source(open_wire_source), .aux_regulator_on(aux_regulator_on),
    .discharge_switch(discharge_switch), .charge_switch(charge_switch), .shutdown_req(shutdown_req));
  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  // Slot counter and hang guard; the run needs about 15000 cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    ow_prev <= open_wire_source;
    if (open_wire_source != 7'h00 && open_wire_source != ow_prev)
      ow_cnt <= ow_cnt + 1;
    if (cyc == 40000)
    begin
      fails = fails + 1;
      test_done;
    end
  end
  function [31:0] xs(input [31:0] s);
    reg [31:0] v;
  begin
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    xs = v ^ (v << 5);
  end
  endfunction
  task chk(input [15:0] g, input [15:0] e);
  begin
    tests_run = tests_run + 1;
    if (g !== e)
    begin
      fails = fails + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  end
  endtask
  task test_done;
  begin
    $display("checks=%0d mismatches=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask
  // Inputs are synchronised, so the tick waits for them to settle first
  task tick(input integer gap);
  begin
    repeat (4) @(posedge clk);
    check_tick <= 1'b1;
    @(posedge clk);
    check_tick <= 1'b0;
    repeat (gap) @(posedge clk);
    #1;
  end
  endtask
  task rst;
  begin
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    #1;
  end
  endtask
  task cold_step(input integer c);
  begin
    thermistor_code <= c[7:0];
    tick(6);
    if (ft == 1 && c <= r && r != 0)
      ft = 0;
    else if (ft == 0 && en == 1 && c > t)
    begin
      if (cnt == d)
      begin
        ft = 1;
        al = 0;
        cnt = 0;
      end
      else
      begin
        al = 1;
        cnt = cnt + 1;
      end
    end
    else if (ft == 0)
    begin
      al = 0;
      cnt = 0;
    end
    tdp_host_i.rd_reg(8'h02, q);
    tdp_host_i.rd_reg(8'h03, q2);
    chk({13'h0000, q[0], q2[0], discharge_switch}, {13'h0000, al[0], ft[0], ~ft[0]});
  end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    #1;
    for (i = 8'h40; i < 8'h49; i = i + 1)
    begin
      tdp_host_i.rd_reg(i[7:0], q);
      chk(q, 16'h0000);
    end
    for (i = 8'h41; i < 8'h44; i = i + 1)
    begin
      seed = xs(seed);
      tdp_host_i.wr_reg(i[7:0], {8'h00, seed[7:0]});
      tdp_host_i.rd_reg(i[7:0], q);
      chk(q, {8'h00, seed[7:0]});
    end
    tdp_host_i.wr_reg(8'h7F, seed[15:0]);
    tdp_host_i.rd_reg(8'h7F, q);
    chk(q, 16'h0000);
    seed = xs(seed);
    tdp_host_i.xfer(1'b1, 1'b0, 8'h00, seed[15:0], q);
    tdp_host_i.xfer(1'b0, 1'b1, 8'h00, 16'h0000, q);
    tdp_host_i.xfer(1'b0, 1'b1, 8'h00, 16'h0000, q2);
    tdp_host_i.idle;
    chk(q, SIG);
    chk({15'h0000, q2 === SIG}, 16'h0000);
    tdp_host_i.rd_reg(8'h4A, q);
    chk(q, seed[15:0]);
    seed = xs(seed);
    t = 20 + seed % 200;
    d = 2;
    r = t - 5;
    tdp_host_i.wr_reg(8'h41, t[15:0]);
    tdp_host_i.wr_reg(8'h42, d[15:0]);
    tdp_host_i.wr_reg(8'h43, r[15:0]);
    tdp_host_i.wr_reg(8'h44, 16'h0001);
    tdp_host_i.wr_reg(8'h48, 16'h0001);
    tdp_host_i.wr_reg(8'h4B, 16'h0003);
    en = 0;
    cnt = 0;
    al = 0;
    ft = 0;
    cold_step(t + 1);
    tdp_host_i.wr_reg(8'h40, 16'h0001);
    en = 1;
    for (i = 0; i < 9; i = i + 1)
      cold_step(t + ofs[i]);
    tdp_host_i.wr_reg(8'h43, 16'h0000);
    tdp_host_i.wr_reg(8'h42, 16'h0000);
    r = 0;
    d = 0;
    cold_step(t + 1);
    cold_step(0);
    tdp_host_i.recover(1'b1, 1'b0);
    ft = 0;
    cold_step(0);
    tdp_host_i.wr_reg(8'h40, 16'h0007);
    tdp_host_i.wr_reg(8'h45, 16'h0006);
    for (k = 1; k < 3; k = k + 1)
    begin
      vref_deviation <= (k == 1);
      gnd_above_limit <= (k == 2);
      tick(6);
      tdp_host_i.rd_reg(8'h02, q);
      chk({15'h0000, q[k]}, 16'h0001);
      tick(6);
      vref_deviation <= 1'b0;
      gnd_above_limit <= 1'b0;
      tdp_host_i.rd_reg(8'h03, q);
      chk({13'h0000, q[k], charge_switch, discharge_switch}, 16'h0004);
      tick(6);
      tdp_host_i.rd_reg(8'h03, q);
      chk({15'h0000, q[k]}, 16'h0001);
      tdp_host_i.recover(1'b0, 1'b1);
      tdp_host_i.rd_reg(8'h03, q);
      chk({13'h0000, q[k], charge_switch, discharge_switch}, 16'h0003);
    end
    tdp_host_i.wr_reg(8'h40, 16'h000F);
    tdp_host_i.wr_reg(8'h45, 16'h000E);
    tdp_host_i.wr_reg(8'h69, 16'h0009);
    tdp_host_i.wr_reg(8'h47, 16'h0001);
    aux_reg_ilimit <= 1'b1;
    repeat (8) @(posedge clk);
    tdp_host_i.rd_reg(8'h05, q);
    chk({13'h0000, q[0], aux_regulator_on, charge_switch}, 16'h0004);
    aux_reg_ilimit <= 1'b0;
    repeat (8) @(posedge clk);
    tdp_host_i.rd_reg(8'h05, q);
    chk({13'h0000, q[0], aux_regulator_on, shutdown_req}, 16'h0002);
    aux_reg_overtemp <= 1'b1;
    repeat (8) @(posedge clk);
    chk({15'h0000, shutdown_req}, 16'h0001);
    rst;
    aux_reg_overtemp <= 1'b0;
    osc_fault <= 1'b1;
    repeat (8) @(posedge clk);
    chk({15'h0000, shutdown_req}, 16'h0000);
    tdp_host_i.wr_reg(8'h47, 16'h0002);
    repeat (4) @(posedge clk);
    chk({15'h0000, shutdown_req}, 16'h0001);
    osc_fault <= 1'b0;
    rst;
    trim_error <= 1'b1;
    repeat (8) @(posedge clk);
    chk({15'h0000, shutdown_req}, 16'h0001);
    trim_error <= 1'b0;
    rst;
    for (i = 0; i < 8; i = i + 1)
    begin
      tdp_host_i.wr_reg(8'h46, 16'h0008 | i[15:0]);
      k = ow_cnt;
      repeat (8) tick(195);
      chk(16'(ow_cnt - k), 16'((i < 4) ? (1 << i) : (8 << (i - 3))));
      tdp_host_i.wr_reg(8'h46, 16'h0000);
      repeat (200) @(posedge clk);
    end
    // Frozen clock enable must drop the write
    ce <= 1'b0;
    tdp_host_i.wr_reg(8'h41, 16'h00AA);
    ce <= 1'b1;
    tdp_host_i.rd_reg(8'h41, q);
    chk(q, 16'h0000);
    test_done;
  end
endmodule
